/* File: logic/miu_pkg.sv */
// Purpose: Constants, register map and shared arithmetic for the math instruction unit.
// Assumes: 32-bit APB register access, one 250 MHz clock, synchronous active-high reset.
// Notes: Also holds the one-hot state encoding and the quotient rounding function.

package miu_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_SRC = 8'h04;
    localparam logic [7:0] ADDR_RATE = 8'h08;
    localparam logic [7:0] ADDR_OFFSET = 8'h0C;
    localparam logic [7:0] ADDR_MATH = 8'h10;
    localparam logic [7:0] ADDR_DEST = 8'h14;
    localparam logic [7:0] ADDR_FLAGS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

    // ************************************************************
    // Fields, operations and reset values
    // ************************************************************
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_COND_BIT = 4;
    localparam int CMD_BUSY_BIT = 8;
    localparam logic [1:0] OP_DOUBLE_DIVIDE = 2'h0;
    localparam logic [1:0] OP_ZERO_DESTINATION = 2'h1;
    localparam logic [1:0] OP_SQUARE_ROOT = 2'h2;
    localparam logic [1:0] OP_SCALE = 2'h3;
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_S = 3;
    localparam int IRQ_MINOR = 0;
    localparam int IRQ_DONE = 1;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [31:0] RST_MATH = 32'h0000_0000;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0] RST_IRQ = 2'h0;
    localparam logic [15:0] POS_LIMIT = 16'h7FFF;
    localparam logic [15:0] NEG_LIMIT = 16'h8000;
    localparam logic signed [33:0] WIDE_POS_LIMIT = 34'sh000007FFF;
    localparam logic signed [33:0] WIDE_NEG_LIMIT = 34'sh3FFFF8000;
    localparam logic signed [33:0] RATE_DIVISOR = 34'sh000002710;
    localparam logic [3:0] ROOT_TOP_STEP = 4'h8;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_ROOT = 2'b10
    } miu_state_type;

    // Rounds a truncated quotient away from zero when twice the remainder reaches the divisor.
    function automatic logic signed [33:0] miu_round_q(
        input logic signed [33:0] q,
        input logic signed [33:0] r,
        input logic signed [33:0] d
    );
        logic [33:0] ar;
        logic [33:0] ad;
        logic neg;
        ar = r[33] ? 34'(-r) : 34'(r);
        ad = d[33] ? 34'(-d) : 34'(d);
        neg = r[33] ^ d[33];
        if (r != 34'sh000000000 && {ar[32:0], 1'b0} >= ad)
        begin
            miu_round_q = neg ? 34'(q - 34'sh000000001) : 34'(q + 34'sh000000001);
        end
        else
        begin
            miu_round_q = q;
        end
    endfunction : miu_round_q

endpackage : miu_pkg

/* File: logic/miu_root.sv */
// Purpose: Iterative square root with rounding to the nearest integer.
// Assumes: Start is a one-cycle pulse taken only while not busy.
// Notes: Result is ready nine enabled cycles after start.
`timescale 1ns/1ns

module miu_root
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic [16:0] value,
    output logic done,
    output logic busy,
    output logic [8:0] root
);

    logic [16:0] val_q;
    logic [8:0] rt_q;
    logic [3:0] step_q;
    logic run_q;
    logic done_q;
    logic [8:0] root_q;

    // ************************************************************
    // Trial bit and rounding
    // ************************************************************
    wire [8:0] trial = rt_q | 9'(9'h001 << step_q);
    wire [17:0] trial_sq = 18'(trial * trial);
    wire keep = trial_sq <= {1'b0, val_q};
    wire [8:0] floor_rt = keep ? trial : rt_q;
    wire [17:0] floor_sq = 18'(floor_rt * floor_rt);
    wire [17:0] excess = 18'({1'b0, val_q} - floor_sq);
    wire [8:0] rounded = (excess > {9'h000, floor_rt}) ? 9'(floor_rt + 9'h001) : floor_rt;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            val_q <= 17'h00000;
            rt_q <= 9'h000;
            step_q <= 4'h0;
            run_q <= 1'b0;
            done_q <= 1'b0;
            root_q <= 9'h000;
        end
        else if (ce)
        begin
            done_q <= 1'b0;
            if (start && !run_q)
            begin
                val_q <= value;
                rt_q <= 9'h000;
                step_q <= miu_pkg::ROOT_TOP_STEP;
                run_q <= 1'b1;
            end
            else if (run_q)
            begin
                rt_q <= floor_rt;
                step_q <= 4'(step_q - 4'h1);
                if (step_q == 4'h0)
                begin
                    run_q <= 1'b0;
                    done_q <= 1'b1;
                    root_q <= rounded;
                end
            end
        end
    end

    assign done = done_q;
    assign busy = run_q;
    assign root = root_q;

endmodule : miu_root

/* File: logic/miu_top.sv */
// Purpose: Math instruction unit: double divide, zero destination, square root and scale.
// Assumes: APB slave with zero wait states; operations start by a write of the command register.
// Notes: Square root takes ten enabled cycles; the others finish at the command write edge.
`timescale 1ns/1ns

module miu_top
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);

    // ************************************************************
    // State
    // ************************************************************
    miu_pkg::miu_state_type state_q;
    miu_pkg::miu_state_type state_d;
    logic [15:0] src_q;
    logic [15:0] rate_q;
    logic [15:0] offset_q;
    logic [31:0] math_q;
    logic [31:0] math_d;
    logic [15:0] dest_q;
    logic [15:0] dest_d;
    logic [3:0] flags_q;
    logic [3:0] flags_d;
    logic [1:0] last_op_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [31:0] prdata_q;
    logic root_neg_q;
    logic root_done;
    logic root_busy;
    logic [8:0] root_val;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire access = psel && penable;
    wire addr_hit = paddr == miu_pkg::ADDR_CMD || paddr == miu_pkg::ADDR_SRC
        || paddr == miu_pkg::ADDR_RATE || paddr == miu_pkg::ADDR_OFFSET
        || paddr == miu_pkg::ADDR_MATH || paddr == miu_pkg::ADDR_DEST
        || paddr == miu_pkg::ADDR_FLAGS || paddr == miu_pkg::ADDR_IRQ_STAT
        || paddr == miu_pkg::ADDR_IRQ_MASK;
    wire wr_en = access && pwrite && ce;
    wire busy = state_q == miu_pkg::ST_ROOT;
    wire cmd_wr = wr_en && paddr == miu_pkg::ADDR_CMD && !busy;
    wire cond = pwdata[miu_pkg::CMD_COND_BIT];
    wire [1:0] op = pwdata[miu_pkg::CMD_OP_LSB +: 2];
    wire fire = cmd_wr && cond;
    wire fire_ddv = fire && op == miu_pkg::OP_DOUBLE_DIVIDE;
    wire fire_clr = fire && op == miu_pkg::OP_ZERO_DESTINATION;
    wire fire_sqr = fire && op == miu_pkg::OP_SQUARE_ROOT;
    wire fire_scl = fire && op == miu_pkg::OP_SCALE;
    wire commit_root = root_done && ce && busy;
    wire irq_clr_wr = wr_en && paddr == miu_pkg::ADDR_IRQ_STAT;

    assign pready = 1'b1;
    assign pslverr = access && !addr_hit;
    assign prdata = prdata_q;

    wire [31:0] rd_mux =
        (paddr == miu_pkg::ADDR_CMD) ? {23'h000000, busy, 6'h00, last_op_q} :
        (paddr == miu_pkg::ADDR_SRC) ? {16'h0000, src_q} :
        (paddr == miu_pkg::ADDR_RATE) ? {16'h0000, rate_q} :
        (paddr == miu_pkg::ADDR_OFFSET) ? {16'h0000, offset_q} :
        (paddr == miu_pkg::ADDR_MATH) ? math_q :
        (paddr == miu_pkg::ADDR_DEST) ? {16'h0000, dest_q} :
        (paddr == miu_pkg::ADDR_FLAGS) ? {28'h0000000, flags_q} :
        (paddr == miu_pkg::ADDR_IRQ_STAT) ? {30'h00000000, irq_stat_q} :
        (paddr == miu_pkg::ADDR_IRQ_MASK) ? {30'h00000000, irq_mask_q} :
        32'h0000_0000;

    // ************************************************************
    // Double divide datapath
    // ************************************************************
    wire logic signed [33:0] dvd = {{2{math_q[31]}}, math_q};
    wire div_zero = src_q == 16'h0000;
    wire logic signed [33:0] dvs = div_zero ? 34'sh000000001 : {{18{src_q[15]}}, src_q};
    wire logic signed [33:0] ddv_q = dvd / dvs;
    wire logic signed [33:0] ddv_r = dvd % dvs;
    wire logic signed [33:0] ddv_rnd = miu_pkg::miu_round_q(ddv_q, ddv_r, dvs);
    // Saturation to the positive limit does not depend on any overflow-selection setting.
    wire ddv_ovf = div_zero || ddv_rnd > miu_pkg::WIDE_POS_LIMIT
        || ddv_rnd < miu_pkg::WIDE_NEG_LIMIT;
    wire [15:0] ddv_res = ddv_ovf ? miu_pkg::POS_LIMIT : ddv_rnd[15:0];
    wire [31:0] ddv_math = div_zero ? math_q : {ddv_q[15:0], ddv_r[15:0]};

    // ************************************************************
    // Scale datapath
    // ************************************************************
    wire logic signed [31:0] prod = $signed(src_q) * $signed(rate_q);
    wire logic signed [33:0] prod_w = {{2{prod[31]}}, prod};
    wire logic signed [33:0] scl_q = prod_w / miu_pkg::RATE_DIVISOR;
    wire logic signed [33:0] scl_r = prod_w % miu_pkg::RATE_DIVISOR;
    wire logic signed [33:0] scaled =
        miu_pkg::miu_round_q(scl_q, scl_r, miu_pkg::RATE_DIVISOR);
    wire logic signed [33:0] offset_w = {{18{offset_q[15]}}, offset_q};
    wire logic signed [33:0] scl_sum = 34'(scaled + offset_w);
    wire pre_hi = scaled > miu_pkg::WIDE_POS_LIMIT;
    wire pre_lo = scaled < miu_pkg::WIDE_NEG_LIMIT;
    wire post_hi = scl_sum > miu_pkg::WIDE_POS_LIMIT;
    wire post_lo = scl_sum < miu_pkg::WIDE_NEG_LIMIT;
    wire scl_ovf = pre_hi || pre_lo || post_hi || post_lo;
    // A high product saturates before the offset is even considered.
    wire [15:0] scl_res = pre_hi ? miu_pkg::POS_LIMIT :
        pre_lo ? miu_pkg::NEG_LIMIT :
        post_hi ? miu_pkg::POS_LIMIT :
        post_lo ? miu_pkg::NEG_LIMIT : scl_sum[15:0];

    // ************************************************************
    // Square root
    // ************************************************************
    wire src_neg = src_q[15];
    // The magnitude of the most negative source needs seventeen bits.
    wire [16:0] root_arg = src_neg ? 17'(17'h00000 - {src_q[15], src_q}) : {1'b0, src_q};

    miu_root u_root
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(fire_sqr),
        .value(root_arg),
        .done(root_done),
        .busy(root_busy),
        .root(root_val)
    );

    // ************************************************************
    // Result and flag selection
    // ************************************************************
    wire minor_set = (fire_ddv && ddv_ovf) || (fire_scl && scl_ovf);
    wire done_set = fire_ddv || fire_clr || fire_scl || commit_root;

    always_comb
    begin
        dest_d = dest_q;
        flags_d = flags_q;
        math_d = math_q;
        state_d = state_q;
        case (state_q)
            miu_pkg::ST_IDLE:
            begin
                if (fire_ddv)
                begin
                    dest_d = ddv_res;
                    math_d = ddv_math;
                    flags_d[miu_pkg::FLG_C] = 1'b0;
                    flags_d[miu_pkg::FLG_V] = ddv_ovf;
                    flags_d[miu_pkg::FLG_Z] = !ddv_ovf && ddv_res == 16'h0000;
                    flags_d[miu_pkg::FLG_S] = !ddv_ovf && ddv_res[15];
                end
                else if (fire_clr)
                begin
                    dest_d = 16'h0000;
                    flags_d = 4'h0;
                    flags_d[miu_pkg::FLG_Z] = 1'b1;
                end
                else if (fire_scl)
                begin
                    dest_d = scl_res;
                    flags_d[miu_pkg::FLG_V] = scl_ovf;
                    flags_d[miu_pkg::FLG_Z] = scl_res == 16'h0000;
                    flags_d[miu_pkg::FLG_S] = scl_res[15];
                end
                else if (fire_sqr)
                begin
                    state_d = miu_pkg::ST_ROOT;
                end
            end
            miu_pkg::ST_ROOT:
            begin
                if (root_done)
                begin
                    dest_d = {7'h00, root_val};
                    flags_d[miu_pkg::FLG_C] = root_neg_q;
                    flags_d[miu_pkg::FLG_V] = 1'b0;
                    flags_d[miu_pkg::FLG_Z] = root_val == 9'h000;
                    flags_d[miu_pkg::FLG_S] = 1'b0;
                    state_d = miu_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_d = miu_pkg::ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Commands with a false condition reach none of the state below.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= miu_pkg::ST_IDLE;
            dest_q <= miu_pkg::RST_WORD;
            flags_q <= miu_pkg::RST_FLAGS;
            root_neg_q <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            dest_q <= dest_d;
            flags_q <= flags_d;
            if (fire_sqr)
            begin
                root_neg_q <= src_neg;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            src_q <= miu_pkg::RST_WORD;
            rate_q <= miu_pkg::RST_WORD;
            offset_q <= miu_pkg::RST_WORD;
            math_q <= miu_pkg::RST_MATH;
            last_op_q <= 2'h0;
        end
        else if (ce)
        begin
            math_d_wr: math_q <= (wr_en && paddr == miu_pkg::ADDR_MATH && !busy)
                ? pwdata : math_d;
            if (wr_en && paddr == miu_pkg::ADDR_SRC && !busy)
            begin
                src_q <= pwdata[15:0];
            end
            if (wr_en && paddr == miu_pkg::ADDR_RATE && !busy)
            begin
                rate_q <= pwdata[15:0];
            end
            if (wr_en && paddr == miu_pkg::ADDR_OFFSET && !busy)
            begin
                offset_q <= pwdata[15:0];
            end
            if (fire)
            begin
                last_op_q <= op;
            end
        end
    end

    // ************************************************************
    // Interrupt and read data
    // ************************************************************
    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_stat_q <= miu_pkg::RST_IRQ;
            irq_mask_q <= miu_pkg::RST_IRQ;
            prdata_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            irq_stat_q <= (irq_stat_q & ~(irq_clr_wr ? pwdata[1:0] : 2'h0))
                | {done_set, minor_set};
            if (wr_en && paddr == miu_pkg::ADDR_IRQ_MASK)
            begin
                irq_mask_q <= pwdata[1:0];
            end
            if (psel && !penable)
            begin
                prdata_q <= rd_mux;
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ************************************************************
    // Assertions
    // ************************************************************
    a_ddv_zero_div: assert property (@(posedge clk) disable iff (rst)
        fire_ddv && div_zero |=> flags_q[miu_pkg::FLG_V] && dest_q == 16'h7FFF
            && irq_stat_q[miu_pkg::IRQ_MINOR] && $stable(math_q))
        else $error("Divide by zero did not saturate and flag.");

    a_ddv_carry_zero: assert property (@(posedge clk) disable iff (rst)
        fire_ddv |=> !flags_q[miu_pkg::FLG_C]
            && (flags_q[miu_pkg::FLG_Z] == (dest_q == 16'h0000 && !flags_q[miu_pkg::FLG_V])))
        else $error("Double divide carry or zero flag wrong.");

    a_ddv_math_rem: assert property (@(posedge clk) disable iff (rst)
        fire_ddv && !div_zero |=> math_q[31:16] == 16'($past(dvd) / $past(dvs))
            && math_q[15:0] == 16'($past(dvd) % $past(dvs)))
        else $error("Math register does not hold quotient and remainder.");

    a_ddv_round_up: assert property (@(posedge clk) disable iff (rst)
        fire_ddv && !ddv_ovf && !ddv_r[33] && !dvs[33] && ddv_r != 34'sh000000000
            && 34'(ddv_r + ddv_r) >= dvs |=> dest_q == 16'($past(ddv_q) + 34'sh000000001))
        else $error("Double divide did not round the quotient up.");

    a_clr_flags: assert property (@(posedge clk) disable iff (rst)
        fire_clr |=> dest_q == 16'h0000 && flags_q == 4'h4)
        else $error("Zero destination left wrong result or flags.");

    a_root_flags: assert property (@(posedge clk) disable iff (rst)
        commit_root |=> dest_q == {7'h00, $past(root_val)} && !flags_q[miu_pkg::FLG_V]
            && !flags_q[miu_pkg::FLG_S] && flags_q[miu_pkg::FLG_C] == $past(root_neg_q)
            && flags_q[miu_pkg::FLG_Z] == (dest_q == 16'h0000))
        else $error("Square root result or flags wrong.");

    a_root_no_fault: assert property (@(posedge clk) disable iff (rst)
        fire_sqr && src_neg |-> ##[10:40] (commit_root && root_neg_q && !minor_set))
        else $error("Negative square root did not finish cleanly.");

    a_root_in_step: assert property (@(posedge clk) disable iff (rst)
        root_busy |-> busy)
        else $error("Root engine runs while the unit is idle.");

    a_scl_saturate: assert property (@(posedge clk) disable iff (rst)
        fire_scl && scl_ovf |=> flags_q[miu_pkg::FLG_V]
            && (dest_q == 16'h7FFF || dest_q == 16'h8000) && irq_stat_q[miu_pkg::IRQ_MINOR])
        else $error("Scale overflow did not saturate.");

    a_scl_pre_high: assert property (@(posedge clk) disable iff (rst)
        fire_scl && pre_hi |=> dest_q == 16'h7FFF)
        else $error("Scale ignoring offset on high product failed.");

    a_scl_carry_kept: assert property (@(posedge clk) disable iff (rst)
        fire_scl |=> $stable(flags_q[miu_pkg::FLG_C])
            && flags_q[miu_pkg::FLG_S] == dest_q[15])
        else $error("Scale disturbed carry or set a wrong sign.");

    a_false_cond: assert property (@(posedge clk) disable iff (rst)
        cmd_wr && !cond |=> $stable(dest_q) && $stable(flags_q) && $stable(math_q))
        else $error("False condition changed unit state.");

endmodule : miu_top

/* File: tb/math_instruction_unit_bench.sv */
// Purpose: Self-checking bench for the math instruction unit over APB.
// Assumes: ce high except for one frozen write; IRQ mask enables only the minor error bit.
// Notes: Corner cases first, then random operands from a fixed seed.
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module math_instruction_unit_bench;
logic clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic pready, pslverr, irq, perr, minor;
logic signed [15:0] src, rate, off, ed;
logic signed [31:0] mth;
logic signed [33:0] q, r, p;
logic [3:0] ef = 4'h0;
int errors = 0, samples_checked = 0, cyc = 0, i;
always #2 clk = ~clk;
miu_top miu_top_inst(.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
endtask : apb

// Works out the destination, flags and math register from the operands.
task predict(input logic [1:0] op);
    logic [16:0] a;
    logic [8:0] t;
    if (op == 2'h0)
    begin
        q = (src == 16'sh0) ? 34'sh10000 : mth / src;
        r = (src == 16'sh0) ? 34'sh0 : mth % src;
        p = q;
        if (r != 0 && 2 * (r < 0 ? -r : r) >= (src < 0 ? -src : src))
            p = q + (((r < 0) != (src < 0)) ? -1 : 1);
        minor = p > 32767 || p < -32768;
        if (src != 16'sh0)
            mth = {q[15:0], r[15:0]};
        ed = minor ? 16'sh7FFF : p[15:0];
        ef = {!minor && p < 0, !minor && p == 0, minor, 1'b0};
    end
    else if (op == 2'h1)
    begin
        ed = 16'sh0;
        ef = 4'h4;
    end
    else if (op == 2'h2)
    begin
        a = src[15] ? 17'(-{src[15], src}) : {1'b0, src};
        t = 9'h0;
        while ((t + 9'h1) * (t + 9'h1) <= a)
            t++;
        if (a - t * t > t)
            t++;
        ed = {7'h0, t};
        ef = {1'b0, t == 9'h0, 1'b0, src[15]};
    end
    else
    begin
        p = src * rate;
        q = p / 10000;
        r = p % 10000;
        if (2 * (r < 0 ? -r : r) >= 10000)
            q = q + (p < 0 ? -1 : 1);
        minor = q > 32767 || q < -32768;
        if (!minor)
            q = q + off;
        p = (q > 32767) ? 34'sh7FFF : (q < -32768) ? -34'sh8000 : q;
        minor = minor || p != q;
        ed = p[15:0];
        ef = {ed < 0, ed == 16'sh0, minor, ef[0]};
    end
endtask : predict

// Loads operands, issues one command and checks every result register.
task tc(input logic [1:0] op, input logic c, input int s, input int rt, input int o, input int m);
    int n;
    src = 16'(s);
    rate = 16'(rt);
    off = 16'(o);
    mth = m;
    apb(1'b1, miu_pkg::ADDR_SRC, {16'h0, src});
    apb(1'b1, miu_pkg::ADDR_RATE, {16'h0, rate});
    apb(1'b1, miu_pkg::ADDR_OFFSET, {16'h0, off});
    apb(1'b1, miu_pkg::ADDR_MATH, mth);
    apb(1'b1, miu_pkg::ADDR_CMD, {27'h0, c, 2'h0, op});
    n = 0;
    do
    begin
        apb(1'b0, miu_pkg::ADDR_CMD, 32'h0);
        n++;
    end
    while (rd[miu_pkg::CMD_BUSY_BIT] !== 1'b0 && n < 30);
    `CHK(rd[miu_pkg::CMD_BUSY_BIT], 1'b0)
    if (c) `CHK(rd[1:0], op)
    minor = 1'b0;
    if (c)
        predict(op);
    apb(1'b0, miu_pkg::ADDR_DEST, 32'h0);
    `CHK(rd[15:0], ed)
    apb(1'b0, miu_pkg::ADDR_FLAGS, 32'h0);
    `CHK(rd[3:0], ef)
    apb(1'b0, miu_pkg::ADDR_MATH, 32'h0);
    `CHK(rd, mth)
    `CHK(irq, minor)
    apb(1'b0, miu_pkg::ADDR_IRQ_STAT, 32'h0);
    `CHK(rd[1:0], {c, minor})
    apb(1'b1, miu_pkg::ADDR_IRQ_STAT, 32'h3);
    `CHK(irq, 1'b0)
endtask : tc

task results;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask : results

always @(posedge clk)
begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
        errors++;
        results();
    end
end

initial
begin
    void'($urandom(32'h4AD13E04));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i <= 32; i += 4)
    begin
        apb(1'b0, 8'(i), 32'h0);
        `CHK(rd, 32'h0)
    end
    apb(1'b0, 8'h40, 32'h0);
    `CHK(perr, 1'b1)
    `CHK(rd, 32'h0)
    // A write while the clock enable is low must be lost.
    ce <= 1'b0;
    apb(1'b1, miu_pkg::ADDR_SRC, 32'h1234);
    ce <= 1'b1;
    apb(1'b0, miu_pkg::ADDR_SRC, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, miu_pkg::ADDR_IRQ_MASK, 32'h1);
    tc(2'h0, 1'b1, 0, 0, 0, 1234);
    tc(2'h0, 1'b1, 1, 0, 0, 32'h7FFFFFFF);
    tc(2'h0, 1'b1, 2, 0, 0, 7);
    tc(2'h0, 1'b1, 2, 0, 0, -7);
    tc(2'h1, 1'b1, 5, 0, 0, 99);
    tc(2'h2, 1'b1, -32768, 0, 0, 5);
    tc(2'h3, 1'b1, 32767, 32767, -32768, 5);
    tc(2'h3, 1'b1, 10000, 10000, 30000, 5);
    tc(2'h3, 1'b1, -32768, 10000, -1, 5);
    tc(2'h2, 1'b1, 0, 0, 0, 5);
    tc(2'h0, 1'b0, 3, 0, 0, 77);
    for (i = 0; i < 40; i++)
    begin
        src = 16'($urandom);
        tc(2'(i), ($urandom % 8) != 0, src, 16'($urandom), 16'($urandom),
            src * $signed(16'($urandom)) + $signed(16'($urandom)));
    end
    results();
end
endmodule : math_instruction_unit_bench
